// ### rsd_datapath.sv
// Purpose: rotate-right and subtract-with-borrow datapath of the core
// Assumes: op_valid pulses one cycle with op, mem_rd_data and ld_* stable
// Notes:   results appear on the clock edge that takes the operation
`timescale 1ns/10ps

module rsd_datapath
  import rsd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       op_valid,
  input  wire rsd_op_t    op,
  input  wire logic [7:0] mem_rd_data,
  input  wire logic [7:0] ld_acc,
  input  wire rsd_flags_t ld_flags,
  output logic [7:0]      acc,
  output rsd_flags_t      flags,
  output logic            mem_wr_en,
  output logic [7:0]      mem_wr_data
);

  rsd_state_t state;
  rsd_state_t next_state;

  logic       borrow_in;
  logic [8:0] diff;
  logic [4:0] low_diff;
  logic [7:0] rot_plain;
  logic [7:0] rot_carry;
  logic       sub_ovf;
  logic [8:0] chk_diff;

  // shared arithmetic terms
  always_comb
  begin
    borrow_in = ~state.flags.carry_flag;
    diff      = {1'b0, state.acc} - {1'b0, mem_rd_data}
                - {8'h00, borrow_in};
    low_diff  = {1'b0, state.acc[3:0]} - {1'b0, mem_rd_data[3:0]}
                - {4'h0, borrow_in};
    rot_plain = {mem_rd_data[0], mem_rd_data[RSD_MSB:1]};
    rot_carry = {state.flags.carry_flag, mem_rd_data[RSD_MSB:1]};
    sub_ovf   = (state.acc[RSD_MSB] ^ mem_rd_data[RSD_MSB])
              & (state.acc[RSD_MSB] ^ diff[RSD_MSB]);
  end

  // next state per operation
  always_comb
  begin
    next_state           = state;
    next_state.mem_wr_en = 1'b0;
    if (op_valid)
    begin
      case (op)
        rsd_op_rotate_right_to_accumulator:
        begin
          next_state.acc = rot_plain;
        end
        rsd_op_rotate_right_through_carry:
        begin
          next_state.mem_wr_en        = 1'b1;
          next_state.mem_wr_data      = rot_carry;
          next_state.flags.carry_flag = mem_rd_data[0];
        end
        rsd_op_rotate_right_carry_to_accumulator:
        begin
          next_state.acc              = rot_carry;
          next_state.flags.carry_flag = mem_rd_data[0];
        end
        rsd_op_subtract_with_borrow_to_accumulator,
        rsd_op_subtract_with_borrow_to_memory:
        begin
          if (op == rsd_op_subtract_with_borrow_to_accumulator)
          begin
            next_state.acc = diff[RSD_MSB:0];
          end
          else
          begin
            next_state.mem_wr_en   = 1'b1;
            next_state.mem_wr_data = diff[RSD_MSB:0];
          end
          next_state.flags.carry_flag          = ~diff[RSD_W];
          next_state.flags.range_exceeded_flag = sub_ovf;
          next_state.flags.result_nil_flag     =
            (diff[RSD_MSB:0] == 8'h00);
          next_state.flags.half_carry_flag     = low_diff[RSD_NIB];
          next_state.flags.signed_borrow_flag  =
            sub_ovf ^ diff[RSD_MSB];
          next_state.flags.chained_equal_flag  =
            (diff[RSD_MSB:0] == 8'h00)
            & state.flags.result_nil_flag;
        end
        rsd_op_load_state:
        begin
          next_state.acc   = ld_acc;
          next_state.flags = ld_flags;
        end
        default:
        begin
          next_state.mem_wr_en = 1'b0;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= RSD_STATE_RST;
    else
      state <= next_state;
  end

  // outputs straight from state
  assign acc         = state.acc;
  assign flags       = state.flags;
  assign mem_wr_en   = state.mem_wr_en;
  assign mem_wr_data = state.mem_wr_data;

  // checks on the datapath
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // adder-form reference difference for checks; bit 8 means no borrow
  assign chk_diff = {1'b0, state.acc} + {1'b0, ~mem_rd_data}
                    + {8'h00, state.flags.carry_flag};

  sequence s_op(rsd_op_t o);
    op_valid && op == o;
  endsequence

  sequence s_sub;
    op_valid && (op == rsd_op_subtract_with_borrow_to_accumulator ||
                 op == rsd_op_subtract_with_borrow_to_memory);
  endsequence

  sequence s_rot_c;
    op_valid && (op == rsd_op_rotate_right_through_carry ||
                 op == rsd_op_rotate_right_carry_to_accumulator);
  endsequence

  property p_rot_acc;
    s_op(rsd_op_rotate_right_to_accumulator) |=>
      acc == {$past(mem_rd_data[0]), $past(mem_rd_data[7:1])}
      && flags == $past(flags) && !mem_wr_en;
  endproperty
  a_rot_acc: assert property (p_rot_acc)
    else $error("rotate to acc wrong");

  property p_rot_mem;
    s_op(rsd_op_rotate_right_through_carry) |=>
      mem_wr_en && mem_wr_data == {$past(flags.carry_flag),
                                   $past(mem_rd_data[7:1])}
      && flags.carry_flag == $past(mem_rd_data[0]);
  endproperty
  a_rot_mem: assert property (p_rot_mem)
    else $error("rotate through carry wrong");

  property p_rot_cacc;
    s_op(rsd_op_rotate_right_carry_to_accumulator) |=>
      acc == {$past(flags.carry_flag), $past(mem_rd_data[7:1])}
      && flags.carry_flag == $past(mem_rd_data[0]) && !mem_wr_en;
  endproperty
  a_rot_cacc: assert property (p_rot_cacc)
    else $error("rotate carry to acc wrong");

  property p_rot_flags;
    s_rot_c |=>
      {flags.range_exceeded_flag, flags.result_nil_flag,
       flags.half_carry_flag, flags.signed_borrow_flag,
       flags.chained_equal_flag} ==
      {$past(flags.range_exceeded_flag), $past(flags.result_nil_flag),
       $past(flags.half_carry_flag), $past(flags.signed_borrow_flag),
       $past(flags.chained_equal_flag)};
  endproperty
  a_rot_flags: assert property (p_rot_flags)
    else $error("rotate touched other flags");

  property p_sub_acc;
    s_op(rsd_op_subtract_with_borrow_to_accumulator) |=>
      acc == 8'($past(acc) - $past(mem_rd_data)
                - {7'h00, ~$past(flags.carry_flag)}) && !mem_wr_en;
  endproperty
  a_sub_acc: assert property (p_sub_acc)
    else $error("subtract to acc wrong");

  property p_sub_mem;
    s_op(rsd_op_subtract_with_borrow_to_memory) |=>
      mem_wr_en && acc == $past(acc) && mem_wr_data ==
      8'($past(acc) - $past(mem_rd_data)
         - {7'h00, ~$past(flags.carry_flag)});
  endproperty
  a_sub_mem: assert property (p_sub_mem)
    else $error("subtract to memory wrong");

  property p_sub_carry;
    s_sub |=> flags.carry_flag ==
      ({1'b0, $past(acc)} >= {1'b0, $past(mem_rd_data)}
       + {8'h00, ~$past(flags.carry_flag)});
  endproperty
  a_sub_carry: assert property (p_sub_carry)
    else $error("subtract carry wrong");

  property p_sub_zero;
    s_sub |=>
      flags.result_nil_flag == ($past(chk_diff[7:0]) == 8'h00)
      && flags.signed_borrow_flag ==
         (flags.range_exceeded_flag ^ $past(chk_diff[7]))
      && flags.chained_equal_flag ==
         (($past(chk_diff[7:0]) == 8'h00)
          && $past(flags.result_nil_flag));
  endproperty
  a_sub_zero: assert property (p_sub_zero)
    else $error("subtract zero or sign flag wrong");

  property p_sub_ovh;
    s_sub |=> flags.range_exceeded_flag ==
      (($past(acc[7]) != $past(mem_rd_data[7]))
       && ($past(acc[7]) != $past(chk_diff[7])))
      && flags.half_carry_flag ==
      ({1'b0, $past(acc[3:0])} < {1'b0, $past(mem_rd_data[3:0])}
       + {4'h0, ~$past(flags.carry_flag)});
  endproperty
  a_sub_ovh: assert property (p_sub_ovh)
    else $error("overflow or half carry wrong");

endmodule : rsd_datapath

// ### rsd_pkg.sv
// Purpose: shared types and constants for the rotate/subtract datapath
// Assumes: 8-bit accumulator and data memory bytes
// Notes:   flags travel as one packed struct
package rsd_pkg;

  localparam int RSD_W      = 8;
  localparam int RSD_MSB    = 7;
  localparam int RSD_NIB    = 4;
  localparam logic [7:0] RSD_ACC_RST = 8'h00;

  // operation select; op_load_state preloads acc and flags
  typedef enum logic [2:0] {
    rsd_op_rotate_right_to_accumulator        = 3'h0,
    rsd_op_rotate_right_through_carry         = 3'h1,
    rsd_op_rotate_right_carry_to_accumulator  = 3'h2,
    rsd_op_subtract_with_borrow_to_accumulator = 3'h3,
    rsd_op_subtract_with_borrow_to_memory     = 3'h4,
    rsd_op_load_state                         = 3'h5
  } rsd_op_t;

  // status flags
  typedef struct packed {
    logic range_exceeded_flag;
    logic result_nil_flag;
    logic half_carry_flag;
    logic carry_flag;
    logic signed_borrow_flag;
    logic chained_equal_flag;
  } rsd_flags_t;

  localparam rsd_flags_t RSD_FLAGS_RST = '0;

  // whole state of the datapath
  typedef struct packed {
    logic [7:0] acc;
    rsd_flags_t flags;
    logic       mem_wr_en;
    logic [7:0] mem_wr_data;
  } rsd_state_t;

  localparam rsd_state_t RSD_STATE_RST = '0;

endpackage : rsd_pkg

// ### rotate_subtract_datapath_tb.sv
// Purpose: self-checking bench for the rotate/subtract datapath
// Assumes: inputs change on the falling edge, results seen one edge later
// Notes:   subtract expectations are computed here from the operand values; the other tests check fixed values
`timescale 1ns/10ps
module rotate_subtract_datapath_tb
  import rsd_pkg::*;
;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       op_valid = 1'b0;
  rsd_op_t    op = rsd_op_load_state;
  logic [7:0] mem_rd_data = 8'h00;
  logic [7:0] ld_acc = 8'h00;
  rsd_flags_t ld_flags = RSD_FLAGS_RST;
  logic [7:0] acc;
  rsd_flags_t flags;
  logic       mem_wr_en;
  logic [7:0] mem_wr_data;
  int         bad_count = 0;
  int         cmp_count = 0;
  logic [13:0] e;

  // 125 MHz clock
  always #4 clk = ~clk;

  rsd_datapath dut_u (.clk(clk), .rst_n(rst_n), .op_valid(op_valid),
    .op(op), .mem_rd_data(mem_rd_data), .ld_acc(ld_acc),
    .ld_flags(ld_flags), .acc(acc), .flags(flags),
    .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data));

  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // one operation, results visible on return
  task automatic run(input rsd_op_t o, input logic [7:0] m);
    @(negedge clk);
    op_valid = 1'b1;
    op = o;
    mem_rd_data = m;
    @(negedge clk);
    op_valid = 1'b0;
    mem_rd_data = ~m;
  endtask : run

  task automatic load(input logic [7:0] a, input rsd_flags_t f);
    ld_acc = a;
    ld_flags = f;
    run(rsd_op_load_state, 8'h00);
  endtask : load

  // result and flags of a - m - ~c
  function automatic logic [13:0] sub_exp(input logic [7:0] a, m,
                                          input logic c, z0);
    logic [8:0] d;
    logic [4:0] h;
    logic ovf;
    d = {1'b0, a} - {1'b0, m} - {8'h00, ~c};
    h = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, ~c};
    ovf = (a[7] != m[7]) && (d[7] != a[7]);
    return {d[7:0], ovf, d[7:0] == 8'h00, h[4], ~d[8], ovf ^ d[7],
            (d[7:0] == 8'h00) & z0};
  endfunction : sub_exp

  task automatic t_rotates;
    load(8'h5A, 6'h3F);
    run(rsd_op_rotate_right_to_accumulator, 8'h01);
    check(acc, 8'h80);
    check({2'h0, flags}, 8'h3F);
    check({7'h0, mem_wr_en}, 8'h00);
    run(rsd_op_rotate_right_through_carry, 8'h02);
    check(mem_wr_data, 8'h81);
    check({7'h0, mem_wr_en}, 8'h01);
    check({2'h0, flags}, 8'h3B);
    check(acc, 8'h80);
    run(rsd_op_rotate_right_carry_to_accumulator, 8'hFF);
    check(acc, 8'h7F);
    check({2'h0, flags}, 8'h3F);
    check({7'h0, mem_wr_en}, 8'h00);
    check(mem_wr_data, 8'h81);
    $display("test rotates done");
  endtask : t_rotates

  task automatic t_subtract;
    logic [7:0] ta [5] = '{8'h10, 8'h05, 8'h80, 8'h00, 8'h7F};
    logic [7:0] tm [5] = '{8'h01, 8'h05, 8'h01, 8'h00, 8'hFF};
    logic [4:0] tc = 5'b10111;
    logic [4:0] tz = 5'b01010;
    for (int k = 0; k < 2; k++)
      for (int i = 0; i < 5; i++)
      begin
        e = sub_exp(ta[i], tm[i], tc[i], tz[i]);
        load(ta[i], {1'b0, tz[i], 1'b0, tc[i], 2'b00});
        run(k ? rsd_op_subtract_with_borrow_to_memory
              : rsd_op_subtract_with_borrow_to_accumulator, tm[i]);
        check({2'h0, flags}, {2'h0, e[5:0]});
        check({7'h0, flags.carry_flag}, {7'h0, e[2]});
        check({7'h0, flags.range_exceeded_flag}, {7'h0, e[5]});
        check({7'h0, flags.half_carry_flag}, {7'h0, e[3]});
        check(k ? mem_wr_data : acc, e[13:6]);
        check(acc, k ? ta[i] : e[13:6]);
        check({7'h0, mem_wr_en}, {7'h0, k[0]});
        @(negedge clk);
        check({7'h0, mem_wr_en}, 8'h00);
      end
    $display("test subtract done");
  endtask : t_subtract

  task automatic t_ignored;
    load(8'h33, 6'h15);
    @(negedge clk);
    op_valid = 1'b1;
    op = rsd_op_t'(3'h6);
    mem_rd_data = 8'hF0;
    @(negedge clk);
    op = rsd_op_subtract_with_borrow_to_accumulator;
    op_valid = 1'b0;
    @(negedge clk);
    check(acc, 8'h33);
    check({2'h0, flags}, 8'h15);
    check({7'h0, mem_wr_en}, 8'h00);
    $display("test ignored ops done");
  endtask : t_ignored

  // reset in mid-run clears all outputs, then operations resume
  task automatic t_reset;
    load(8'hA5, 6'h3F);
    run(rsd_op_rotate_right_through_carry, 8'h02);
    rst_n = 1'b0;
    @(negedge clk);
    check(acc, RSD_ACC_RST);
    check({2'h0, flags}, 8'h00);
    check(mem_wr_data, 8'h00);
    check({7'h0, mem_wr_en}, 8'h00);
    @(negedge clk);
    rst_n = 1'b1;
    run(rsd_op_rotate_right_to_accumulator, 8'h03);
    check(acc, 8'h81);
    check({2'h0, flags}, 8'h00);
    check({7'h0, mem_wr_en}, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  // main sequence
  initial
  begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    check(acc, RSD_ACC_RST);
    check({2'h0, flags}, 8'h00);
    t_rotates();
    t_subtract();
    t_ignored();
    t_reset();
    close_out();
  end

  // watchdog, far beyond the roughly 75 cycles needed
  initial
  begin
    #100000;
    bad_count++;
    close_out();
  end
endmodule : rotate_subtract_datapath_tb
